// *** design/host_access_pkg.sv ***
package host_access_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;

    // Word address of the interrupt status register; a read of it releases the interrupt.
    localparam logic [ADDR_W-1:0] IRQ_STATUS_WORD = 13'h12C3;

    // Word returned during an interrupt acknowledge cycle; the value is arbitrary.
    localparam logic [DATA_W-1:0] IRQ_VECTOR_WORD = 16'h00F0;

    // Serial frame length and operation-select codes (mode pin 1 is the high bit).
    localparam logic [4:0] SER_LAST_BIT   = 5'h0F;
    localparam logic [1:0] SER_WRITE_REG  = 2'h0;
    localparam logic [1:0] SER_READ_REG   = 2'h1;
    localparam logic [1:0] SER_WRITE_ADDR = 2'h2;
    localparam logic [1:0] SER_NO_ACTION  = 2'h3;

    // Levels of the parallel direction input and of the port select input.
    localparam logic DIR_WRITE   = 1'b0;
    localparam logic SEL_SERIAL  = 1'b0;
    localparam logic SEL_PARALLEL = 1'b1;

    // One access request towards the internal registers and buffers.
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // One word taken from memory during a DMA transfer.
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } dma_word_t;

    typedef enum logic [2:0] {P_IDLE, P_RD_ISSUE, P_RD_CAPTURE, P_ACK, P_RELEASE} par_state_t;
    typedef enum logic [2:0] {D_IDLE, D_REQ, D_WAIT, D_RDY, D_PULL} dma_state_t;

endpackage : host_access_pkg

// *** design/serial_slave.sv ***
module serial_slave (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         en_i,
    input  wire logic                         sclk_i,
    input  wire logic                         mosi_i,
    input  wire logic [1:0]                   mode_i,
    input  wire logic                         load_i,
    input  wire logic [host_access_pkg::DATA_W-1:0] rdata_i,
    output logic                              miso_o,
    output host_access_pkg::reg_req_t         req_o
);

    logic                                 sclk_q;
    logic [4:0]                           cnt_q;
    logic [host_access_pkg::DATA_W-1:0]   sh_q;
    logic [host_access_pkg::ADDR_W-1:0]   addr_q;
    logic                                 armed_q;
    logic                                 rise;
    logic                                 frame_end;
    logic [host_access_pkg::DATA_W-1:0]   word;

    // The serial clock is a plain synchronous input, so its edges are found by comparison.
    assign rise      = sclk_i & ~sclk_q;
    assign frame_end = en_i && rise && cnt_q == host_access_pkg::SER_LAST_BIT;
    assign word      = {sh_q[host_access_pkg::DATA_W-2:0], mosi_i};
    assign miso_o    = sh_q[host_access_pkg::DATA_W-1];

    // Edge history of the serial clock.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sclk_q <= 1'b0;
        else
            sclk_q <= sclk_i;
    end

    // Bit counter; the no-action code or a disabled port holds the frame at its start.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_i || mode_i == host_access_pkg::SER_NO_ACTION)
            cnt_q <= 5'h00;
        else if (frame_end)
            cnt_q <= 5'h00;
        else if (rise)
            cnt_q <= cnt_q + 5'h01;
    end

    // Shift register, most significant bit first in both directions; read data reloads it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sh_q <= '0;
        else if (load_i)
            sh_q <= rdata_i;
        else if (en_i && rise)
            sh_q <= word;
    end

    // The stored address stays in force until another address frame arrives.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            addr_q <= '0;
        else if (frame_end && mode_i == host_access_pkg::SER_WRITE_ADDR)
            addr_q <= word[host_access_pkg::ADDR_W-1:0];
    end

    // One read per frame, issued before the first bit so the MSB is ready in time.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_i || frame_end)
            armed_q <= 1'b0;
        else if (mode_i == host_access_pkg::SER_READ_REG && cnt_q == 5'h00)
            armed_q <= 1'b1;
    end

    // Register requests: a write at the end of a write frame, a read at a read frame start.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            req_o <= '0;
        else
        begin
            req_o.wr    <= frame_end && mode_i == host_access_pkg::SER_WRITE_REG;
            req_o.rd    <= en_i && !armed_q && cnt_q == 5'h00 &&
                           mode_i == host_access_pkg::SER_READ_REG;
            req_o.addr  <= addr_q;
            req_o.wdata <= word;
        end
    end

    addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        frame_end && mode_i == host_access_pkg::SER_WRITE_ADDR |=>
        addr_q == $past(word[host_access_pkg::ADDR_W-1:0]) ##1 $stable(addr_q) || frame_end)
        else $error("Serial address not stored from an address frame.");
    no_action_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_i == host_access_pkg::SER_NO_ACTION |=> cnt_q == 5'h00 && !req_o.wr)
        else $error("Serial no-action code still moved the frame.");
    ser_read_c: cover property (@(posedge clk_i) disable iff (rst_i) req_o.rd ##[1:200] frame_end);

endmodule : serial_slave

// *** design/host_access_port.sv ***
module host_access_port (
    input  wire logic                              SYS_CLK_I,
    input  wire logic                              SYS_RST_I,
    input  wire logic                              HOST_PORT_SELECT_I,
    input  wire logic                              CS_N_I,
    input  wire logic                              RNW_I,
    input  wire logic [host_access_pkg::ADDR_W-1:0] ADDR_I,
    input  wire logic [host_access_pkg::DATA_W-1:0] DATA_I,
    output logic      [host_access_pkg::DATA_W-1:0] DATA_O,
    output logic                                   DATA_OE_N_O,
    input  wire logic                              BUS_CYCLE_HANDSHAKE_N_I,
    output logic                                   BUS_CYCLE_HANDSHAKE_N_O,
    output logic                                   BUS_CYCLE_HANDSHAKE_OE_N_O,
    input  wire logic                              IRQ_EVENT_I,
    input  wire logic                              IRQ_ACKNOWLEDGE_N_I,
    output logic                                   INT_N_O,
    input  wire logic                              DMA_START_I,
    output logic                                   DMA_REQ_N_O,
    input  wire logic                              DMA_GRANT_N_I,
    input  wire logic                              DMA_LAST_N_I,
    output logic                                   DMA_READY_N_O,
    output logic                                   DMA_READY_OE_N_O,
    output host_access_pkg::dma_word_t             DMA_WORD_O,
    input  wire logic                              SER_CLK_I,
    input  wire logic                              SER_MOSI_I,
    output logic                                   SER_MISO_O,
    input  wire logic [1:0]                        SER_MODE_I,
    output host_access_pkg::reg_req_t              REG_REQ_O,
    input  wire logic [host_access_pkg::DATA_W-1:0] REG_RDATA_I
);

    host_access_pkg::par_state_t           p_state_q;
    host_access_pkg::dma_state_t           d_state_q;
    host_access_pkg::reg_req_t             par_req;
    host_access_pkg::reg_req_t             ser_req;
    logic                                  ser_miso;
    logic                                  ser_load;
    logic                                  par_sel;
    logic                                  par_start;
    logic                                  irq_acknowledge_n_q;
    logic                                  irq_pend_q;
    logic                                  irq_pend_d;
    logic                                  isr_read;
    logic                                  last_q;

    // Only the selected port can reach the registers and buffers.
    assign par_sel   = HOST_PORT_SELECT_I == host_access_pkg::SEL_PARALLEL;
    assign par_start = par_sel && !CS_N_I && p_state_q == host_access_pkg::P_IDLE;

    // The address is taken as it stands when chip select falls; the host keeps it settled.
    always_comb
    begin
        par_req       = '0;
        par_req.addr  = ADDR_I;
        par_req.wdata = DATA_I;
        if (par_start && IRQ_ACKNOWLEDGE_N_I)
        begin
            par_req.wr = RNW_I == host_access_pkg::DIR_WRITE;
            par_req.rd = RNW_I != host_access_pkg::DIR_WRITE;
        end
    end

    // Serial read data is loaded in the cycle the register file answers a serial read.
    assign ser_load = REG_REQ_O.rd && !par_sel;

    serial_slave u_serial (
        .clk_i   (SYS_CLK_I),
        .rst_i   (SYS_RST_I),
        .en_i    (HOST_PORT_SELECT_I == host_access_pkg::SEL_SERIAL),
        .sclk_i  (SER_CLK_I),
        .mosi_i  (SER_MOSI_I),
        .mode_i  (SER_MODE_I),
        .load_i  (ser_load),
        .rdata_i (REG_RDATA_I),
        .miso_o  (ser_miso),
        .req_o   (ser_req)
    );

    // Single request register shared by both ports; the port select picks the source.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            REG_REQ_O <= '0;
        else
            REG_REQ_O <= par_sel ? par_req : ser_req;
    end

    // Slave output data, registered once more so the pin comes from a flip-flop.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            SER_MISO_O <= 1'b0;
        else
            SER_MISO_O <= ser_miso;
    end

    // Parallel cycle sequencer: reads wait one cycle for the register file, then drive data.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            p_state_q <= host_access_pkg::P_IDLE;
        else
            unique case (p_state_q)
                host_access_pkg::P_IDLE:
                    if (par_start)
                        p_state_q <= (RNW_I == host_access_pkg::DIR_WRITE) ?
                                     host_access_pkg::P_ACK : host_access_pkg::P_RD_ISSUE;
                host_access_pkg::P_RD_ISSUE:
                    p_state_q <= host_access_pkg::P_RD_CAPTURE;
                host_access_pkg::P_RD_CAPTURE:
                    p_state_q <= host_access_pkg::P_ACK;
                host_access_pkg::P_ACK:
                    if (CS_N_I)
                        p_state_q <= host_access_pkg::P_RELEASE;
                host_access_pkg::P_RELEASE:
                    p_state_q <= host_access_pkg::P_IDLE;
            endcase
    end

    // An interrupt acknowledge cycle returns the vector word instead of a register.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            irq_acknowledge_n_q <= 1'b0;
        else if (par_start)
            irq_acknowledge_n_q <= !IRQ_ACKNOWLEDGE_N_I;
    end

    // Read data bus: captured while the read request still stands, so the register file
    // answer is taken in its own cycle, and driven a cycle ahead of the acknowledge.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            DATA_O      <= '0;
            DATA_OE_N_O <= 1'b1;
        end
        else if (p_state_q == host_access_pkg::P_RD_ISSUE)
        begin
            DATA_O      <= irq_acknowledge_n_q ? host_access_pkg::IRQ_VECTOR_WORD : REG_RDATA_I;
            DATA_OE_N_O <= 1'b0;
        end
        else if (CS_N_I || p_state_q == host_access_pkg::P_IDLE)
            DATA_OE_N_O <= 1'b1;
    end

    // Shared handshake pin: an acknowledge output for host cycles, an input during DMA.
    // The pin is driven high for one cycle before release at the end of a host cycle, but not when DMA releases it during the acknowledge.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            BUS_CYCLE_HANDSHAKE_N_O    <= 1'b1;
            BUS_CYCLE_HANDSHAKE_OE_N_O <= 1'b1;
        end
        else if (par_start && RNW_I == host_access_pkg::DIR_WRITE)
        begin
            BUS_CYCLE_HANDSHAKE_N_O    <= 1'b0;
            BUS_CYCLE_HANDSHAKE_OE_N_O <= 1'b0;
        end
        else if (p_state_q == host_access_pkg::P_RD_CAPTURE)
        begin
            BUS_CYCLE_HANDSHAKE_N_O    <= 1'b0;
            BUS_CYCLE_HANDSHAKE_OE_N_O <= 1'b0;
        end
        else if (p_state_q == host_access_pkg::P_ACK && CS_N_I)
            BUS_CYCLE_HANDSHAKE_N_O    <= 1'b1;
        else if (p_state_q == host_access_pkg::P_RELEASE || d_state_q != host_access_pkg::D_IDLE)
            BUS_CYCLE_HANDSHAKE_OE_N_O <= 1'b1;
    end

    // Pending interrupt: a new event wins over a status read in the same cycle.
    assign isr_read   = REG_REQ_O.rd && REG_REQ_O.addr == host_access_pkg::IRQ_STATUS_WORD;
    assign irq_pend_d = IRQ_EVENT_I || (irq_pend_q && !isr_read);

    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            irq_pend_q <= 1'b0;
            INT_N_O    <= 1'b1;
        end
        else
        begin
            irq_pend_q <= irq_pend_d;
            INT_N_O    <= !irq_pend_d;
        end
    end

    // DMA sequencer: request, wait for grant and memory data, signal ready, repeat until last.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            d_state_q <= host_access_pkg::D_IDLE;
        else
            unique case (d_state_q)
                host_access_pkg::D_IDLE:
                    if (DMA_START_I)
                        d_state_q <= host_access_pkg::D_REQ;
                host_access_pkg::D_REQ:
                    if (!DMA_GRANT_N_I)
                        d_state_q <= host_access_pkg::D_WAIT;
                host_access_pkg::D_WAIT:
                    if (!DMA_GRANT_N_I && !BUS_CYCLE_HANDSHAKE_N_I)
                        d_state_q <= host_access_pkg::D_RDY;
                host_access_pkg::D_RDY:
                    if (BUS_CYCLE_HANDSHAKE_N_I)
                        d_state_q <= host_access_pkg::D_PULL;
                host_access_pkg::D_PULL:
                    d_state_q <= last_q ? host_access_pkg::D_IDLE : host_access_pkg::D_WAIT;
            endcase
    end

    // The last-transfer mark is remembered for the transfer in progress only.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I || d_state_q == host_access_pkg::D_PULL)
            last_q <= 1'b0;
        else if ((d_state_q == host_access_pkg::D_WAIT || d_state_q == host_access_pkg::D_RDY) &&
                 !DMA_LAST_N_I)
            last_q <= 1'b1;
    end

    // Request stays low for the whole burst and is withdrawn once the last transfer ends.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            DMA_REQ_N_O <= 1'b1;
        else if (d_state_q == host_access_pkg::D_IDLE && DMA_START_I)
            DMA_REQ_N_O <= 1'b0;
        else if (d_state_q == host_access_pkg::D_PULL && last_q)
            DMA_REQ_N_O <= 1'b1;
    end

    // Ready: low while the memory cycle completes, high for one cycle, then released.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            DMA_READY_N_O    <= 1'b1;
            DMA_READY_OE_N_O <= 1'b1;
        end
        else if (d_state_q == host_access_pkg::D_WAIT && !DMA_GRANT_N_I && !BUS_CYCLE_HANDSHAKE_N_I)
        begin
            DMA_READY_N_O    <= 1'b0;
            DMA_READY_OE_N_O <= 1'b0;
        end
        else if (d_state_q == host_access_pkg::D_RDY && BUS_CYCLE_HANDSHAKE_N_I)
            DMA_READY_N_O    <= 1'b1;
        else if (d_state_q == host_access_pkg::D_PULL)
            DMA_READY_OE_N_O <= 1'b1;
    end

    // Memory data is taken while the memory holds its handshake low.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (SYS_RST_I)
            DMA_WORD_O <= '0;
        else
        begin
            DMA_WORD_O.valid <= d_state_q == host_access_pkg::D_WAIT && !DMA_GRANT_N_I &&
                                !BUS_CYCLE_HANDSHAKE_N_I;
            DMA_WORD_O.data  <= DATA_I;
        end
    end

    unselected_port_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        !par_sel && p_state_q == host_access_pkg::P_IDLE |=>
        p_state_q == host_access_pkg::P_IDLE && BUS_CYCLE_HANDSHAKE_OE_N_O && DATA_OE_N_O)
        else $error("Parallel port answered while the serial port is selected.");
    write_taken_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        par_start && !RNW_I && IRQ_ACKNOWLEDGE_N_I |=>
        REG_REQ_O.wr && !BUS_CYCLE_HANDSHAKE_N_O && !BUS_CYCLE_HANDSHAKE_OE_N_O)
        else $error("Write not taken with acknowledge one cycle after chip select.");
    read_data_first_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        par_start && RNW_I |=> DATA_OE_N_O ##1 !DATA_OE_N_O && BUS_CYCLE_HANDSHAKE_N_O ##1
        !DATA_OE_N_O && !BUS_CYCLE_HANDSHAKE_N_O)
        else $error("Read data not driven a cycle ahead of the acknowledge.");
    ack_release_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        p_state_q == host_access_pkg::P_ACK && CS_N_I |=>
        BUS_CYCLE_HANDSHAKE_N_O && !BUS_CYCLE_HANDSHAKE_OE_N_O ##1 BUS_CYCLE_HANDSHAKE_OE_N_O)
        else $error("Acknowledge not pulled high and released after chip select.");
    irq_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        isr_read && !IRQ_EVENT_I |=> INT_N_O)
        else $error("Interrupt not released by a status register read.");
    irq_set_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        IRQ_EVENT_I |=> !INT_N_O)
        else $error("Interrupt event lost.");
    dma_request_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        d_state_q == host_access_pkg::D_IDLE && DMA_START_I |=> !DMA_REQ_N_O)
        else $error("DMA request not raised on start.");
    dma_input_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        d_state_q == host_access_pkg::D_WAIT |-> BUS_CYCLE_HANDSHAKE_OE_N_O)
        else $error("Handshake pin driven while DMA memory owns it.");
    ready_release_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        $rose(DMA_READY_N_O) |-> !DMA_READY_OE_N_O ##1 DMA_READY_OE_N_O)
        else $error("Ready not held high before release.");
    burst_end_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        d_state_q == host_access_pkg::D_PULL && last_q |=> DMA_REQ_N_O && d_state_q == host_access_pkg::D_IDLE)
        else $error("Burst did not end after the last transfer.");

    par_write_c: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) REG_REQ_O.wr && par_sel);
    par_read_c: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        p_state_q == host_access_pkg::P_RD_CAPTURE ##1 !BUS_CYCLE_HANDSHAKE_N_O);
    dma_burst_c: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        d_state_q == host_access_pkg::D_PULL && !last_q ##[1:20] d_state_q == host_access_pkg::D_PULL && last_q);

endmodule : host_access_port

// *** verification/dma_memory_model.sv ***
module dma_memory_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        grant_n_i,
    input  wire logic        ready_n_i,
    input  wire logic [3:0]  burst_i,
    output logic             hs_en_o,
    output logic             last_n_o,
    output logic [15:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    int k;
    // One word per handshake while grant stays low; the strobe is held until ready is seen low or 20 cycles pass, then for one cycle more.
    initial
    begin
        hs_en_o = 1'b0;
        last_n_o = 1'b1;
        data_o = 16'h0000;
        n = 0;
        forever
        begin
            @(posedge clk_i);
            if (!rst_i && grant_n_i === 1'b0)
            begin
                hs_en_o <= 1'b1;
                data_o <= 16'hC000 + 16'(n);
                last_n_o <= (n + 1 == int'(burst_i)) ? 1'b0 : 1'b1;
                for (k = 0; k < 20 && ready_n_i !== 1'b0; k++) @(posedge clk_i);
                @(posedge clk_i);
                hs_en_o <= 1'b0;
                data_o <= ~data_o; // A released bus must not keep its last value.
                last_n_o <= 1'b1;
                n = (n + 1 == int'(burst_i)) ? 0 : n + 1;
                repeat (3) @(posedge clk_i);
            end
        end
    end
endmodule : dma_memory_model

// *** verification/host_access_port_test.sv ***
module host_access_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, sel = 1, cs_n = 1, rnw = 1, evt = 0, irq_acknowledge_n_n = 1, start = 0, grant_n = 1;
    logic        sclk = 0, mosi = 0;
    logic [1:0]  mode = 2'h3;
    logic [12:0] addr = 13'h0000;
    logic [15:0] host_d = 16'h0000, data_i, data_o, mem_d, rdat;
    logic        oe_n, hs, hs_n_o, hs_oe_n, int_n, req_n, rdy_n, rdy_oe_n, mem_en, last_n, miso;
    host_access_pkg::reg_req_t  req, last_req;
    host_access_pkg::dma_word_t dw;
    logic [15:0] words[$];
    int miscompares = 0, n_tests = 0, k;
    always #5 clk = ~clk;
    // The pin is pulled high when nobody drives it; memory only ever pulls it low.
    assign hs = !hs_oe_n ? hs_n_o : (mem_en ? 1'b0 : 1'b1);
    assign data_i = mem_en ? mem_d : host_d;
    // The register file answers only while a read request stands.
    assign rdat = req.rd ? ({3'b000, req.addr} ^ 16'hA5A5) : 16'h0000;
    always @(posedge clk) grant_n <= req_n;
    always @(posedge clk) if (req.wr | req.rd) last_req <= req;
    always @(posedge clk) if (dw.valid) words.push_back(dw.data);
    host_access_port dut_u (.SYS_CLK_I(clk), .SYS_RST_I(rst), .HOST_PORT_SELECT_I(sel), .CS_N_I(cs_n),
        .RNW_I(rnw), .ADDR_I(addr), .DATA_I(data_i), .DATA_O(data_o), .DATA_OE_N_O(oe_n),
        .BUS_CYCLE_HANDSHAKE_N_I(hs), .BUS_CYCLE_HANDSHAKE_N_O(hs_n_o), .BUS_CYCLE_HANDSHAKE_OE_N_O(hs_oe_n),
        .IRQ_EVENT_I(evt), .IRQ_ACKNOWLEDGE_N_I(irq_acknowledge_n_n), .INT_N_O(int_n), .DMA_START_I(start),
        .DMA_REQ_N_O(req_n), .DMA_GRANT_N_I(grant_n), .DMA_LAST_N_I(last_n), .DMA_READY_N_O(rdy_n),
        .DMA_READY_OE_N_O(rdy_oe_n), .DMA_WORD_O(dw), .SER_CLK_I(sclk), .SER_MOSI_I(mosi),
        .SER_MISO_O(miso), .SER_MODE_I(mode), .REG_REQ_O(req), .REG_RDATA_I(rdat));
    dma_memory_model mem_u (.clk_i(clk), .rst_i(rst), .grant_n_i(grant_n), .ready_n_i(rdy_n),
        .burst_i(4'h2), .hs_en_o(mem_en), .last_n_o(last_n), .data_o(mem_d));
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task guard(input int n);
        if (n >= 60)
        begin
            miscompares++;
            stop_test();
        end
    endtask : guard
    // One host cycle; chip select is held until the acknowledge is seen, then dropped cleanly.
    task acc(input logic r, input logic [12:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        cs_n <= 1'b0;
        rnw <= r;
        addr <= a;
        host_d <= d;
        for (k = 0; k < 60 && hs !== 1'b0; k++) @(posedge clk);
        guard(k);
        q = data_o;
        chk("data drive", {16'h0000, !r}, {16'h0000, oe_n});
        @(posedge clk);
        cs_n <= 1'b1;
        for (k = 0; k < 60 && hs_oe_n !== 1'b1; k++) @(posedge clk);
        guard(k);
        chk("ack idle", 17'h0_0001, {16'h0000, hs});
        @(posedge clk);
    endtask : acc
    task t_regs;
        logic [15:0] q;
        acc(1'b0, 13'h0123, 16'hBEEF, q);
        chk("wr req", {1'b1, 16'hBEEF}, {last_req.wr, last_req.wdata});
        chk("wr addr", {4'h0, 13'h0123}, {4'h0, last_req.addr});
        acc(1'b1, 13'h1FFF, 16'h0000, q);
        chk("rd data", {1'b0, 16'hA5A5 ^ 16'h1FFF}, {1'b0, q});
        sel <= 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("unselected", 17'h0_0001, {16'h0000, hs_oe_n});
        cs_n <= 1'b1;
        sel <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : t_regs
    // One serial frame, MSB first; each serial clock half period lasts four system cycles.
    task ser(input logic [1:0] m, input logic [15:0] w, output logic [15:0] r);
        mode <= m;
        repeat (4) @(posedge clk);
        for (int i = 15; i >= 0; i--)
        begin
            mosi <= w[i];
            repeat (4) @(posedge clk);
            r[i] = miso;
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (2) @(posedge clk);
        mode <= 2'h3;
        repeat (2) @(posedge clk);
    endtask : ser
    task t_ser;
        logic [15:0] r;
        sel <= 1'b0;
        ser(2'h2, 16'h0ABC, r);
        ser(2'h0, 16'h1234, r);
        chk("ser wr", {1'b1, 16'h1234}, {last_req.wr, last_req.wdata});
        chk("ser addr", {4'h0, 13'h0ABC}, {4'h0, last_req.addr});
        ser(2'h1, 16'h0000, r);
        chk("ser rd", {1'b0, 16'hA5A5 ^ 16'h0ABC}, {1'b0, r});
        sel <= 1'b1;
        @(posedge clk);
    endtask : t_ser
    task t_irq;
        logic [15:0] q;
        evt <= 1'b1;
        @(posedge clk);
        evt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("int set", 17'h0_0000, {16'h0000, int_n});
        irq_acknowledge_n_n <= 1'b0;
        acc(1'b1, 13'h0000, 16'h0000, q);
        irq_acknowledge_n_n <= 1'b1;
        chk("vector", {1'b0, host_access_pkg::IRQ_VECTOR_WORD}, {1'b0, q});
        acc(1'b1, host_access_pkg::IRQ_STATUS_WORD, 16'h0000, q);
        chk("int clr", 17'h0_0001, {16'h0000, int_n});
    endtask : t_irq
    task t_dma;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        chk("dma req", 17'h0_0000, {16'h0000, req_n});
        for (k = 0; k < 60 && req_n !== 1'b1; k++) @(posedge clk);
        guard(k);
        @(posedge clk);
        chk("dma words", 17'h0_0002, 17'(words.size()));
        chk("word 0", {1'b0, 16'hC000}, {1'b0, words[0]});
        chk("word 1", {1'b0, 16'hC001}, {1'b0, words[1]});
        chk("rdy off", 17'h0_0003, {15'h0000, rdy_n, rdy_oe_n});
    endtask : t_dma
    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset outs", 17'h0_001F, {12'h000, int_n, req_n, rdy_oe_n, hs_oe_n, oe_n});
        t_regs();
        t_ser();
        t_irq();
        t_dma();
        stop_test();
    end
endmodule : host_access_port_test
